/* File: rtl/rsww_pkg.sv */
// constants, carriers and state codes of the reset supervisor and window watchdog
// assumes a single 100 MHz clock and a plain register port
package rsww_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ     = 100;                 // clock rate in MHz
	localparam int STARTUP_US  = 1000;                // core start-up time, us
	localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ; // start-up in cycles
	localparam int UV_US       = 23;                  // sense-low to reset-low, us
	localparam int UV_CYC      = UV_US * CLK_MHZ;     // same in cycles
	localparam int SS_DIS_US   = 2;                   // soft-start discharge time, us
	localparam int SS_DIS_CYC  = SS_DIS_US * CLK_MHZ; // same in cycles

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] OFS_RST_DLY  = 8'h00; // reset delay in ramp ticks
	localparam logic [7:0] OFS_POR_RAMP = 8'h04; // cycles per reset-delay ramp
	localparam logic [7:0] OFS_WIN_RAMP = 8'h08; // cycles per window ramp
	localparam logic [7:0] OFS_WIN_LIM  = 8'h0c; // window bounds in ramps
	localparam logic [7:0] OFS_SS_CHG   = 8'h10; // soft-start charge cycles
	localparam logic [7:0] OFS_STATUS   = 8'h14; // live state, read only

	// reset values
	localparam logic [15:0] RST_DLY_RST  = 16'h0010;
	localparam logic [15:0] POR_RAMP_RST = 16'h0064;
	localparam logic [15:0] WIN_RAMP_RST = 16'h0064;
	localparam logic [7:0]  WIN_LOW_RST  = 8'h01;
	localparam logic [7:0]  WIN_UP_RST   = 8'h1f;
	localparam logic [15:0] SS_CHG_RST   = 16'h03e8;

	// window limit field positions
	localparam int WIN_LOW_LSB = 0;
	localparam int WIN_UP_LSB  = 8;

	// status field positions
	localparam int ST_CORE_ON  = 0;
	localparam int ST_RST_LOW  = 1;
	localparam int ST_FAULT    = 2;
	localparam int ST_SWITCH   = 3;
	localparam int ST_UV       = 4;
	localparam int ST_DOG_ON   = 5;
	localparam int ST_WIN_LSB  = 8;

	// ----------------------------------------
	// carriers and states
	// ----------------------------------------
	typedef struct packed {
		logic regulator_en; // regulator enable pin
		logic dog_en;       // watchdog enable pin
		logic kick;         // watchdog kick pin
		logic sense;        // reset sense above threshold
	} rsww_pins_s;

	typedef enum logic [2:0] {
		CORE_OFF   = 3'b001,
		CORE_START = 3'b010,
		CORE_ON    = 3'b100
	} rsww_core_e;

	typedef enum logic [3:0] {
		SS_OFF = 4'b0001,
		SS_DIS = 4'b0010,
		SS_CHG = 4'b0100,
		SS_RUN = 4'b1000
	} rsww_ss_e;

endpackage

/* File: rtl/rsww_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes asynchronous level inputs; output changes once stages two and three agree
`timescale 1ns/1ps
module rsww_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_in,
	output logic [W-1:0]      q_out
);
	logic [W-1:0] s1_q; // first stage, read by s2 only
	logic [W-1:0] s2_q; // second stage
	logic [W-1:0] s3_q; // third stage
	wire  [W-1:0] agree = ~(s2_q ^ s3_q); // per-bit agreement

	// ----------------------------------------
	// stages and filtered output
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			q_out <= '0;
		end else begin
			s1_q  <= d_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			q_out <= (s2_q & agree) | (q_out & ~agree);
		end
	end
endmodule

/* File: rtl/rsww_tick.sv */
// ramp divider: one-cycle tick every period cycles
// assumes period of zero behaves as one; clear restarts the ramp
`timescale 1ns/1ps
module rsww_tick (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic [15:0] period,
	output logic             tick
);
	logic [15:0] cnt_q; // position within ramp
	wire         wrap = (cnt_q + 16'h0001 >= period); // ramp end

	// ----------------------------------------
	// ramp counter
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
			tick  <= 1'b0;
		end else if (clear) begin
			cnt_q <= 16'h0000;
			tick  <= 1'b0;
		end else begin
			cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
			tick  <= wrap;
		end
	end
endmodule

/* File: rtl/rsww_top.sv */
// reset supervisor, window watchdog, core enable and soft-start sequencing
// assumes one 100 MHz clock, asynchronous pins, plain register port
`timescale 1ns/1ps
module rsww_top #(
	parameter int STARTUP_CYC_P = rsww_pkg::STARTUP_CYC // core start-up cycles
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic        regulator_enable_in,
	input  wire logic        dog_enable_in,
	input  wire logic        dog_kick_in,
	input  wire logic        reset_sense_in,
	output logic             supervisor_reset_out_n_o,
	output logic             supervisor_reset_out_n_oe,
	output logic             dog_fault_out_n_o,
	output logic             dog_fault_out_n_oe,
	output logic             switch_enable,
	output logic             softstart_discharge,
	output logic             softstart_charge,
	output logic             core_active
);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	rsww_pkg::rsww_pins_s pin_raw; // raw pins
	rsww_pkg::rsww_pins_s pin;     // filtered pins

	assign pin_raw = '{regulator_en: regulator_enable_in, dog_en: dog_enable_in,
	                   kick: dog_kick_in, sense: reset_sense_in};

	rsww_sync #(.W(4)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d_in    (pin_raw),
		.q_out   (pin)
	);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] rst_dly_q;  // reset delay, ramp ticks
	logic [15:0] por_ramp_q; // cycles per delay ramp
	logic [15:0] win_ramp_q; // cycles per window ramp
	logic [7:0]  win_low_q;  // lower bound, ramps
	logic [7:0]  win_up_q;   // upper bound, ramps
	logic [15:0] ss_chg_q;   // soft-start charge cycles

	// ----------------------------------------
	// core enable and start-up
	// ----------------------------------------
	rsww_pkg::rsww_core_e core_q;     // core state
	logic [16:0]          core_cnt_q; // start-up counter
	wire                  any_en  = pin.regulator_en | pin.dog_en | pin.sense;
	wire                  core_on = (core_q == rsww_pkg::CORE_ON);
	wire                  start_done = (core_cnt_q >= 17'(STARTUP_CYC_P - 1));

	// core sequencing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_q     <= rsww_pkg::CORE_OFF;
			core_cnt_q <= 17'h00000;
		end else begin
			case (core_q)
				rsww_pkg::CORE_OFF: begin
					core_cnt_q <= 17'h00000;
					if (any_en) begin
						core_q <= rsww_pkg::CORE_START;
					end
				end
				rsww_pkg::CORE_START: begin
					core_cnt_q <= core_cnt_q + 17'h00001;
					if (!any_en) begin
						core_q <= rsww_pkg::CORE_OFF;
					end else if (start_done) begin
						core_q <= rsww_pkg::CORE_ON;
					end
				end
				rsww_pkg::CORE_ON: begin
					if (!any_en) begin
						core_q <= rsww_pkg::CORE_OFF;
					end
				end
				default: begin
					core_q <= rsww_pkg::CORE_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// undervoltage filter and reset supervisor
	// ----------------------------------------
	logic [11:0] uv_cnt_q;   // sense-low time
	logic        uv_q;       // undervoltage seen
	logic [15:0] dly_cnt_q;  // reset delay progress
	logic        released_q; // reset released
	logic        por_tick;   // delay ramp tick
	wire         rst_block = !core_on | uv_q;          // forces reset low
	wire         dly_done  = (dly_cnt_q >= rst_dly_q); // delay elapsed

	rsww_tick u_por_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clear   (rst_block | released_q | !pin.sense),
		.period  (por_ramp_q),
		.tick    (por_tick)
	);

	// undervoltage after sense stays low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			uv_cnt_q <= 12'h000;
			uv_q     <= 1'b0;
		end else if (!core_on || pin.sense) begin
			uv_cnt_q <= 12'h000;
			uv_q     <= 1'b0;
		end else if (uv_cnt_q >= 12'(rsww_pkg::UV_CYC - 1)) begin
			uv_q <= 1'b1;
		end else begin
			uv_cnt_q <= uv_cnt_q + 12'h001;
		end
	end

	// reset delay timer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dly_cnt_q  <= 16'h0000;
			released_q <= 1'b0;
		end else if (rst_block) begin
			dly_cnt_q  <= 16'h0000;
			released_q <= 1'b0;
		end else if (!released_q && pin.sense) begin
			// release after delay with sense good
			if (dly_done) begin
				released_q <= 1'b1;
			end else if (por_tick) begin
				dly_cnt_q <= dly_cnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// window watchdog
	// ----------------------------------------
	logic        kick_prev_q; // kick level last cycle
	logic [7:0]  win_cnt_q;   // ramps since last edge
	logic        fault_q;     // fault pulse active
	logic [15:0] flt_cnt_q;   // fault timer progress
	logic        win_tick;    // window ramp tick
	logic        flt_tick;    // fault ramp tick
	wire         dog_on = core_on & pin.dog_en;
	wire         fall   = dog_on & kick_prev_q & !pin.kick;
	wire         early  = fall & (win_cnt_q < win_low_q);
	wire         late   = dog_on & (win_cnt_q >= win_up_q);
	wire         win_restart = !dog_on | fault_q | fall | late;
	wire         flt_done = (flt_cnt_q >= rst_dly_q);

	rsww_tick u_win_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clear   (win_restart),
		.period  (win_ramp_q),
		.tick    (win_tick)
	);

	// fault length uses the reset delay
	rsww_tick u_flt_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clear   (!fault_q),
		.period  (por_ramp_q),
		.tick    (flt_tick)
	);

	// interval measurement
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			kick_prev_q <= 1'b0;
			win_cnt_q   <= 8'h00;
		end else begin
			kick_prev_q <= pin.kick;
			if (win_restart) begin
				win_cnt_q <= 8'h00;
			end else if (win_tick) begin
				win_cnt_q <= win_cnt_q + 8'h01;
			end
		end
	end

	// fault pulse timer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fault_q   <= 1'b0;
			flt_cnt_q <= 16'h0000;
		end else if (!dog_on) begin
			fault_q   <= 1'b0;
			flt_cnt_q <= 16'h0000;
		end else if (!fault_q) begin
			flt_cnt_q <= 16'h0000;
			if (early || late) begin
				fault_q <= 1'b1;
			end
		end else if (flt_done) begin
			fault_q <= 1'b0;
		end else if (flt_tick) begin
			flt_cnt_q <= flt_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// regulator enable and soft-start
	// ----------------------------------------
	rsww_pkg::rsww_ss_e ss_q;     // soft-start state
	logic [15:0]        ss_cnt_q; // phase counter
	// core on and the regulator pin gate this
	wire                reg_on = core_on & pin.regulator_en;

	// soft-start sequencing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ss_q     <= rsww_pkg::SS_OFF;
			ss_cnt_q <= 16'h0000;
		end else if (!reg_on) begin
			ss_q     <= rsww_pkg::SS_OFF;
			ss_cnt_q <= 16'h0000;
		end else begin
			case (ss_q)
				rsww_pkg::SS_OFF: begin
					ss_q <= rsww_pkg::SS_DIS;
				end
				rsww_pkg::SS_DIS: begin
					if (ss_cnt_q >= 16'(rsww_pkg::SS_DIS_CYC - 1)) begin
						ss_q     <= rsww_pkg::SS_CHG;
						ss_cnt_q <= 16'h0000;
					end else begin
						ss_cnt_q <= ss_cnt_q + 16'h0001;
					end
				end
				rsww_pkg::SS_CHG: begin
					if (ss_cnt_q >= ss_chg_q) begin
						ss_q <= rsww_pkg::SS_RUN;
					end else begin
						ss_cnt_q <= ss_cnt_q + 16'h0001;
					end
				end
				rsww_pkg::SS_RUN: begin
					ss_q <= rsww_pkg::SS_RUN;
				end
				default: begin
					ss_q <= rsww_pkg::SS_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	logic [31:0] rd_mux;  // selected read word
	logic [31:0] status;  // live state word
	wire  wr_dly  = reg_wr & (reg_addr == rsww_pkg::OFS_RST_DLY);
	wire  wr_por  = reg_wr & (reg_addr == rsww_pkg::OFS_POR_RAMP);
	wire  wr_win  = reg_wr & (reg_addr == rsww_pkg::OFS_WIN_RAMP);
	wire  wr_lim  = reg_wr & (reg_addr == rsww_pkg::OFS_WIN_LIM);
	wire  wr_ss   = reg_wr & (reg_addr == rsww_pkg::OFS_SS_CHG);

	// status word assembly
	always_comb begin
		status                            = 32'h0000_0000;
		status[rsww_pkg::ST_CORE_ON]      = core_on;
		status[rsww_pkg::ST_RST_LOW]      = !released_q;
		status[rsww_pkg::ST_FAULT]        = fault_q;
		status[rsww_pkg::ST_SWITCH]       = (ss_q == rsww_pkg::SS_RUN);
		status[rsww_pkg::ST_UV]           = uv_q;
		status[rsww_pkg::ST_DOG_ON]       = dog_on;
		status[rsww_pkg::ST_WIN_LSB +: 8] = win_cnt_q;
	end

	// read decode, unmapped reads zero
	always_comb begin
		if (reg_addr == rsww_pkg::OFS_RST_DLY) begin
			rd_mux = {16'h0000, rst_dly_q};
		end else if (reg_addr == rsww_pkg::OFS_POR_RAMP) begin
			rd_mux = {16'h0000, por_ramp_q};
		end else if (reg_addr == rsww_pkg::OFS_WIN_RAMP) begin
			rd_mux = {16'h0000, win_ramp_q};
		end else if (reg_addr == rsww_pkg::OFS_WIN_LIM) begin
			rd_mux = {16'h0000, win_up_q, win_low_q};
		end else if (reg_addr == rsww_pkg::OFS_SS_CHG) begin
			rd_mux = {16'h0000, ss_chg_q};
		end else if (reg_addr == rsww_pkg::OFS_STATUS) begin
			rd_mux = status;
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rst_dly_q  <= rsww_pkg::RST_DLY_RST;
			por_ramp_q <= rsww_pkg::POR_RAMP_RST;
			win_ramp_q <= rsww_pkg::WIN_RAMP_RST;
			win_low_q  <= rsww_pkg::WIN_LOW_RST;
			win_up_q   <= rsww_pkg::WIN_UP_RST;
			ss_chg_q   <= rsww_pkg::SS_CHG_RST;
		end else begin
			if (wr_dly) rst_dly_q <= reg_wdata[15:0];
			if (wr_por) por_ramp_q <= reg_wdata[15:0];
			if (wr_win) win_ramp_q <= reg_wdata[15:0];
			if (wr_ss) ss_chg_q <= reg_wdata[15:0];
			if (wr_lim) begin
				win_low_q <= reg_wdata[rsww_pkg::WIN_LOW_LSB +: 8];
				win_up_q  <= reg_wdata[rsww_pkg::WIN_UP_LSB +: 8];
			end
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata                 <= 32'h0000_0000;
			supervisor_reset_out_n_o  <= 1'b0;
			supervisor_reset_out_n_oe <= 1'b1;
			dog_fault_out_n_o         <= 1'b0;
			dog_fault_out_n_oe        <= 1'b0;
			switch_enable             <= 1'b0;
			softstart_discharge       <= 1'b0;
			softstart_charge          <= 1'b0;
			core_active               <= 1'b0;
		end else begin
			reg_rdata                 <= reg_rd ? rd_mux : 32'h0000_0000;
			supervisor_reset_out_n_o  <= 1'b0;
			supervisor_reset_out_n_oe <= !released_q;
			dog_fault_out_n_o         <= 1'b0;
			dog_fault_out_n_oe        <= fault_q & dog_on;
			switch_enable             <= (ss_q == rsww_pkg::SS_RUN);
			softstart_discharge       <= (ss_q == rsww_pkg::SS_DIS);
			softstart_charge          <= (ss_q == rsww_pkg::SS_CHG) | (ss_q == rsww_pkg::SS_RUN);
			core_active               <= core_on;
		end
	end

endmodule

/* File: verification/rsww_mcu_model.sv */
// microcontroller model: toggles the kick pin, stops while held in reset
// assumes the bench sets the half period and the run flag
`timescale 1ns/1ps
module rsww_mcu_model (
	input  wire logic        clk_sys,
	input  wire logic        run,
	input  wire logic [15:0] half,
	input  wire logic        reset_pin_n,
	output logic             kick
);
	int cnt; // cycles spent in the current level
	initial begin
		kick = 1'b1;
		cnt = 0;
	end
	// falling edges every two half periods
	always @(posedge clk_sys) begin
		if (!run || !reset_pin_n) begin
			cnt <= 0;
		end else if (cnt + 1 >= int'(half)) begin
			cnt <= 0;
			kick <= ~kick;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

/* File: verification/rsww_top_assertions.sv */
// port checker for the supervisor, watchdog and soft-start block
// assumes it is bound to rsww_top and sees only its ports
`timescale 1ns/1ps
module rsww_top_assertions #(
	parameter int STARTUP_CYC_P = 20 // core start-up cycles
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic regulator_enable_in,
	input wire logic dog_enable_in,
	input wire logic reset_sense_in,
	input wire logic supervisor_reset_out_n_oe,
	input wire logic dog_fault_out_n_oe,
	input wire logic switch_enable,
	input wire logic softstart_discharge,
	input wire logic softstart_charge,
	input wire logic core_active
);
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	int  en_cnt; // cycles with any enable or sense high
	int  lo_cnt; // cycles with sense low
	wire any_en = regulator_enable_in | dog_enable_in | reset_sense_in;
	// count enable and sense-low run lengths
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_cnt <= 0;
			lo_cnt <= 0;
		end else begin
			en_cnt <= any_en ? en_cnt + 1 : 0;
			lo_cnt <= reset_sense_in ? 0 : lo_cnt + 1;
		end
	end
	// ----------------------------------------
	// sequences and properties
	// ----------------------------------------
	sequence s_chg_start;
		$rose(softstart_charge);
	endsequence
	sequence s_dog_off;
		!dog_enable_in [*6];
	endsequence
	sequence s_all_off;
		(!regulator_enable_in && !dog_enable_in && !reset_sense_in) [*8];
	endsequence
	property p_core_early;
		$rose(core_active) |-> en_cnt >= STARTUP_CYC_P;
	endproperty
	property p_core_late;
		en_cnt > STARTUP_CYC_P + 8 |-> core_active;
	endproperty
	property p_release;
		$fell(supervisor_reset_out_n_oe) |-> core_active && $past(reset_sense_in, 4);
	endproperty
	property p_uv;
		lo_cnt > rsww_pkg::UV_CYC + 8 |-> supervisor_reset_out_n_oe;
	endproperty
	property p_dog_off;
		s_dog_off |-> !dog_fault_out_n_oe;
	endproperty
	property p_shutdown;
		s_all_off |-> !core_active && supervisor_reset_out_n_oe && !dog_fault_out_n_oe;
	endproperty
	property p_reg_off;
		!regulator_enable_in [*8] |-> !switch_enable && !softstart_charge && !softstart_discharge;
	endproperty
	property p_ss_order;
		s_chg_start |-> $past(softstart_discharge);
	endproperty
	property p_switch;
		switch_enable |-> softstart_charge && core_active;
	endproperty
	property p_fault_cause;
		$rose(dog_fault_out_n_oe) |-> core_active && $past(dog_enable_in, 4);
	endproperty
	a_core_early: assert property (p_core_early)
		else $error("core active before start-up time");
	a_core_late: assert property (p_core_late)
		else $error("core not active after start-up time");
	a_release: assert property (p_release)
		else $error("reset released without sense or core");
	a_uv: assert property (p_uv)
		else $error("reset not asserted after long undervoltage");
	a_dog_off: assert property (p_dog_off)
		else $error("fault driven while watchdog disabled");
	a_shutdown: assert property (p_shutdown)
		else $error("outputs wrong in shutdown");
	a_reg_off: assert property (p_reg_off)
		else $error("regulator active while enable low");
	a_ss_order: assert property (p_ss_order)
		else $error("charge without prior discharge");
	a_switch: assert property (p_switch)
		else $error("switching before soft-start charge");
	a_fault_cause: assert property (p_fault_cause)
		else $error("fault raised while watchdog off");
endmodule

bind rsww_top rsww_top_assertions #(.STARTUP_CYC_P(STARTUP_CYC_P)) i_rsww_top_assertions (
	.clk_sys                  (clk_sys),
	.rst                      (rst),
	.regulator_enable_in      (regulator_enable_in),
	.dog_enable_in            (dog_enable_in),
	.reset_sense_in           (reset_sense_in),
	.supervisor_reset_out_n_oe(supervisor_reset_out_n_oe),
	.dog_fault_out_n_oe       (dog_fault_out_n_oe),
	.switch_enable            (switch_enable),
	.softstart_discharge      (softstart_discharge),
	.softstart_charge         (softstart_charge),
	.core_active              (core_active)
);

/* File: verification/tb.sv */
// testbench for the reset supervisor and window watchdog
// assumes a short start-up parameter and the microcontroller model
`timescale 1ns/1ps
module tb;
	logic        clk_sys   = 1'b0;
	logic        rst       = 1'b1;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        reg_en    = 1'b0;
	logic        dog_en    = 1'b0;
	logic        sense     = 1'b0;
	logic        kick_run  = 1'b0;
	logic [15:0] kick_half = 16'h0019;
	logic [31:0] reg_rdata;
	logic        kick, sup_o, sup_oe, dog_o, dog_oe, sw_en, ss_dis, ss_chg, core;
	wire         reset_pin_n = sup_oe ? sup_o : 1'b1; // pull-up on reset line
	wire  [5:0]  mon = {ss_dis, ss_chg, sw_en, dog_oe, sup_oe, core};
	int          error_cnt = 0;
	int          n_checks  = 0;
	int          n;
	logic [31:0] d;
	logic [31:0] dflt [5] = '{32'(rsww_pkg::RST_DLY_RST), 32'(rsww_pkg::POR_RAMP_RST),
		32'(rsww_pkg::WIN_RAMP_RST), {16'h0, rsww_pkg::WIN_UP_RST, rsww_pkg::WIN_LOW_RST},
		32'(rsww_pkg::SS_CHG_RST)};

	always #5 clk_sys = ~clk_sys;

	rsww_top #(.STARTUP_CYC_P(20)) i_rsww_top (
		.clk_sys                  (clk_sys),
		.rst                      (rst),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_rdata                (reg_rdata),
		.regulator_enable_in      (reg_en),
		.dog_enable_in            (dog_en),
		.dog_kick_in              (kick),
		.reset_sense_in           (sense),
		.supervisor_reset_out_n_o (sup_o),
		.supervisor_reset_out_n_oe(sup_oe),
		.dog_fault_out_n_o        (dog_o),
		.dog_fault_out_n_oe       (dog_oe),
		.switch_enable            (sw_en),
		.softstart_discharge      (ss_dis),
		.softstart_charge         (ss_chg),
		.core_active              (core)
	);

	rsww_mcu_model i_rsww_mcu_model (
		.clk_sys    (clk_sys),
		.run        (kick_run),
		.half       (kick_half),
		.reset_pin_n(reset_pin_n),
		.kick       (kick)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic check_rng(input int v, input int lo, input int hi);
		check({31'h0, v >= lo && v <= hi}, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// bounded wait for one monitored output to reach a level
	task automatic wait_on(input int sel, input logic val, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_sys);
			#1 cnt++;
		end while (mon[sel] !== val && cnt < lim);
		if (mon[sel] !== val) begin
			error_cnt++;
			$display("unexpected timeout at %0t on output %0d", $time, sel);
			finish_test();
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(8'(4 * i), d);
			check(d, dflt[i]);
		end
		rd(8'h18, d);
		check(d, 32'h0);
		wr(8'h14, 32'hffffffff);
		rd(8'h14, d);
		check({29'h0, d[2:0]}, 32'h2);
		wr(8'h00, 32'h4);
		wr(8'h04, 32'h4);
		wr(8'h08, 32'ha);
		wr(8'h10, 32'h32);
		// power-up from sense alone
		@(posedge clk_sys);
		sense <= 1'b1;
		wait_on(0, 1'b1, 60, n);
		check_rng(n, 20, 28);
		wait_on(1, 1'b0, 60, n);
		check_rng(n, 16, 24);
		// soft-start then regulator off
		@(posedge clk_sys);
		reg_en <= 1'b1;
		wait_on(5, 1'b1, 10, n);
		wait_on(4, 1'b1, 260, n);
		check_rng(n, 198, 204);
		wait_on(3, 1'b1, 80, n);
		check_rng(n, 48, 54);
		@(posedge clk_sys);
		reg_en <= 1'b0;
		wait_on(3, 1'b0, 8, n);
		check({31'h0, ss_chg | ss_dis}, 32'h0);
		check({31'h0, sup_oe}, 32'h0);
		// watchdog enable held as a level
		@(posedge clk_sys);
		kick_run <= 1'b1;
		dog_en <= 1'b1;
		n = 0;
		repeat (600) begin
			@(posedge clk_sys);
			n += int'(dog_oe !== 1'b0);
		end
		check(n, 0);
		kick_half <= 16'h0003;
		wait_on(2, 1'b1, 40, n);
		check_rng(n, 1, 40);
		kick_run <= 1'b0;
		wait_on(2, 1'b0, 30, n);
		check_rng(n, 14, 20);
		wait_on(2, 1'b1, 400, n);
		check_rng(n, 305, 320);
		@(posedge clk_sys);
		dog_en <= 1'b0;
		wait_on(2, 1'b0, 8, n);
		repeat (20) @(posedge clk_sys);
		check({31'h0, dog_oe}, 32'h0);
		check({30'h0, sup_o, dog_o}, 32'h0);
		// undervoltage with regulator keeping core alive
		reg_en <= 1'b1;
		@(posedge clk_sys);
		sense <= 1'b0;
		wait_on(1, 1'b1, 2400, n);
		check_rng(n, 2300, 2310);
		// keep sense low a while, reset must stay asserted
		repeat (8) @(posedge clk_sys);
		sense <= 1'b1;
		wait_on(1, 1'b0, 40, n);
		check_rng(n, 16, 24);
		// full shutdown
		@(posedge clk_sys);
		reg_en <= 1'b0;
		sense <= 1'b0;
		wait_on(0, 1'b0, 8, n);
		wait_on(1, 1'b1, 2, n);
		check(n, 1);
		check({31'h0, sup_oe}, 32'h1);
		repeat (10) @(posedge clk_sys);
		finish_test();
	end
endmodule
